/* rtl/cms_pkg.sv */
// Constants, codes and register map of the config message and hint status block.
// Assumes a single user clock; the including module imports the whole package.
package cms_pkg;
  // Function counts and field layout of a requester control word
  localparam int CMS_NUM_PF = 2;
  localparam int CMS_NUM_VF = 6;
  localparam int CMS_ST_W = 3;
  localparam int CMS_REQ_EN_BIT = 8;
  localparam int CMS_ST_LSB = 0;
  // Register port widths and byte offsets
  localparam int CMS_ADDR_W = 8;
  localparam int CMS_REG_W = 16;
  localparam logic [7:0] CMS_FN_CTL_BASE = 8'h00;
  localparam logic [7:0] CMS_FN_CTL_STEP = 8'h04;
  localparam logic [7:0] CMS_STATUS_OFS = 8'h20;
  localparam logic [7:0] CMS_COUNT_OFS = 8'h24;
  // Status register bit positions
  localparam int CMS_STS_TX_BUSY = 0;
  localparam int CMS_STS_RX_BUSY = 1;
  localparam int CMS_STS_PORT_EN = 2;
  localparam int CMS_CNT_W = 8;
  // Received message path
  localparam int CMS_RX_TYPE_W = 5;
  localparam int CMS_RX_LEN_W = 4;
  localparam int CMS_RX_BYTES = 8;
  localparam int CMS_BYTE_W = 8;
  localparam int CMS_BUF_DEPTH = 2;
  // Transmit message codes and per-type data masks
  localparam int CMS_TX_TYPE_W = 3;
  localparam int CMS_TX_DATA_W = 32;
  localparam logic [2:0] CMS_TX_LTR = 3'h0;
  localparam logic [2:0] CMS_TX_OBFF = 3'h1;
  localparam logic [2:0] CMS_TX_SSPL = 3'h2;
  localparam logic [2:0] CMS_TX_PME = 3'h3;
  localparam logic [31:0] CMS_MASK_LTR = 32'h9fff_9fff;
  localparam logic [31:0] CMS_MASK_OBFF = 32'h0000_000f;
  localparam logic [31:0] CMS_MASK_SSPL = 32'h0000_03ff;
  localparam logic [31:0] CMS_MASK_PME = 32'h0000_03f3;
  // State machines
  typedef enum logic [0:0] {CMS_RX_IDLE = 1'b0, CMS_RX_SEND = 1'b1} cms_rx_state_type;
  typedef enum logic [1:0] {
    CMS_TX_IDLE = 2'b00,
    CMS_TX_SEND = 2'b01,
    CMS_TX_DONE = 2'b10
  } cms_tx_state_type;
endpackage

/* rtl/cms_cfg_msg_status.sv */
// Config message ports and hint requester status mirrors of the link core.
// Assumes one user clock, synchronous active-high reset, link-side message
// decoder and transmitter on the same clock, and a simple register port.
// Summary of operation
// RULE1: Two outputs mirror the hint requester enable bit 8 of functions 0 and 1.
// RULE2: A 6-bit output carries the steering tag select of PF0 in 2:0 and PF1 in 5:3.
// RULE3: A 6-bit output mirrors the hint requester enable bit 8 of each virtual function.
// RULE4: An 18-bit output carries a 3-bit steering tag select per virtual function.
// RULE5: A received message raises the received flag for one or more cycles, set by length.
// RULE6: Parameter bytes appear on the 8-bit data bus one per cycle only while received.
// RULE7: The received flag drops for at least one cycle between two messages.
// RULE8: Messages are reported only if the build-time port enable is set.
// RULE9: While received is high a 5-bit code names the message type.
// RULE10: The user holds request, type and data stable until the done pulse.
// RULE11: Transmit types are 0 LTR, 1 OBFF, 2 slot power limit, 3 PM_PME; 4 to 7 reserved.
// RULE12: LTR data holds snoop req/scale/value in 31, 28:26, 25:16 and no-snoop in 15, 12:10, 9:0.
// RULE13: OBFF data holds the OBFF code in bits 3:0.
// RULE14: Slot power limit data holds scale over value in bits 9:0.
// RULE15: PM_PME data flags PF1..PF0 in 1:0 and VF5..VF0 in 9:4, any number at once.
// RULE16: Each transmit request ends with a done pulse exactly one cycle long.
module cms_cfg_msg_status
  import cms_pkg::*;
#(
  parameter bit RX_PORT_EN = 1'b1,
  parameter int NUM_PF = CMS_NUM_PF,
  parameter int NUM_VF = CMS_NUM_VF,
  parameter int BUF_DEPTH = CMS_BUF_DEPTH
) (
  input wire logic i_clk, // User clock
  input wire logic i_reset, // Synchronous reset
  input wire logic [CMS_ADDR_W-1:0] i_reg_addr, // Register byte address
  input wire logic [CMS_REG_W-1:0] i_reg_wdata, // Register write data
  input wire logic i_reg_wr, // Write strobe
  input wire logic i_reg_rd, // Read strobe
  output logic [CMS_REG_W-1:0] o_reg_rdata, // Read data, cycle after strobe
  output logic [NUM_PF-1:0] o_pf_hint_requester_on, // PF requester enables
  output logic [NUM_PF*CMS_ST_W-1:0] o_pf_steering_tag_select, // PF tag modes
  output logic [NUM_VF-1:0] o_vfn_hint_requester_on, // VF requester enables
  output logic [NUM_VF*CMS_ST_W-1:0] o_vfn_steering_tag_select, // VF tag modes
  input wire logic i_link_rx_valid, // Decoded message offered
  output logic o_link_rx_ready, // Buffer can take a message
  input wire logic [CMS_RX_TYPE_W-1:0] i_link_rx_type, // Decoded type
  input wire logic [CMS_RX_LEN_W-1:0] i_link_rx_len, // Parameter byte count
  input wire logic [CMS_RX_BYTES*CMS_BYTE_W-1:0] i_link_rx_params, // Byte 0 low
  output logic o_msg_received, // Message being reported
  output logic [CMS_BYTE_W-1:0] o_msg_received_data, // Parameter byte
  output logic [CMS_RX_TYPE_W-1:0] o_msg_received_type, // Message type
  input wire logic i_msg_transmit, // User transmit request
  input wire logic [CMS_TX_TYPE_W-1:0] i_msg_transmit_type, // Requested type
  input wire logic [CMS_TX_DATA_W-1:0] i_msg_transmit_data, // Requested data
  output logic o_msg_transmit_done, // One-cycle completion
  output logic o_link_tx_valid, // Message offered to link
  input wire logic i_link_tx_ready, // Link took the message
  output logic [CMS_TX_TYPE_W-1:0] o_link_tx_type, // Type to link
  output logic [CMS_TX_DATA_W-1:0] o_link_tx_data // Masked data to link
);
  localparam int NUM_FN = NUM_PF + NUM_VF;
  localparam int ENTRY_W = CMS_RX_TYPE_W + CMS_RX_LEN_W + CMS_RX_BYTES * CMS_BYTE_W;
  localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CNT_W = $clog2(BUF_DEPTH + 1);
  localparam int PAR_W = CMS_RX_BYTES * CMS_BYTE_W;

  logic [NUM_FN-1:0] fn_en_ff;
  logic [NUM_FN*CMS_ST_W-1:0] fn_st_ff;
  logic [CMS_REG_W-1:0] rdata_ff;
  logic [CMS_REG_W-1:0] nxt_rdata;
  logic [ENTRY_W-1:0] buf_mem_ff [BUF_DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [CNT_W-1:0] buf_cnt_ff;
  logic [CNT_W-1:0] nxt_buf_cnt;
  logic rx_ready_ff;
  logic buf_push;
  logic buf_pop;
  logic [ENTRY_W-1:0] head;
  logic [CMS_RX_LEN_W-1:0] head_len;
  cms_rx_state_type rx_state_ff;
  logic [CMS_RX_LEN_W-1:0] rx_remain_ff;
  logic [PAR_W-1:0] rx_par_ff;
  logic rx_recv_ff;
  logic [CMS_BYTE_W-1:0] rx_data_ff;
  logic [CMS_RX_TYPE_W-1:0] rx_type_ff;
  logic [CMS_CNT_W-1:0] rx_count_ff;
  logic [CMS_CNT_W-1:0] tx_count_ff;
  cms_tx_state_type tx_state_ff;
  logic tx_valid_ff;
  logic [CMS_TX_TYPE_W-1:0] tx_type_ff;
  logic [CMS_TX_DATA_W-1:0] tx_data_ff;
  logic tx_done_ff;
  logic tx_reserved;
  logic [CMS_TX_DATA_W-1:0] tx_mask;

  // Mirror outputs are slices of the per-function control flops
  assign o_pf_hint_requester_on = fn_en_ff[NUM_PF-1:0]; // [RULE1]
  assign o_pf_steering_tag_select = fn_st_ff[NUM_PF*CMS_ST_W-1:0]; // [RULE2]
  assign o_vfn_hint_requester_on = fn_en_ff[NUM_FN-1:NUM_PF]; // [RULE3]
  assign o_vfn_steering_tag_select = fn_st_ff[NUM_FN*CMS_ST_W-1:NUM_PF*CMS_ST_W]; // [RULE4]
  assign o_reg_rdata = rdata_ff;
  assign o_link_rx_ready = rx_ready_ff;
  assign o_msg_received = rx_recv_ff;
  assign o_msg_received_data = rx_data_ff;
  assign o_msg_received_type = rx_type_ff;
  assign o_msg_transmit_done = tx_done_ff;
  assign o_link_tx_valid = tx_valid_ff;
  assign o_link_tx_type = tx_type_ff;
  assign o_link_tx_data = tx_data_ff;

  // One control word per function: PFs first, then VFs, in ascending order
  for (genvar f = 0; f < NUM_FN; f++) begin : g_fn
    localparam logic [7:0] FN_OFS = 8'(CMS_FN_CTL_BASE + f * CMS_FN_CTL_STEP);
    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        fn_en_ff[f] <= 1'b0;
        fn_st_ff[f*CMS_ST_W +: CMS_ST_W] <= '0;
      end else if (i_reg_wr && i_reg_addr == FN_OFS) begin
        fn_en_ff[f] <= i_reg_wdata[CMS_REQ_EN_BIT]; // [RULE1] [RULE3]
        fn_st_ff[f*CMS_ST_W +: CMS_ST_W] <= i_reg_wdata[CMS_ST_LSB +: CMS_ST_W]; // [RULE2] [RULE4]
      end
    end
  end

  // Read decode; unmapped addresses and reserved bits read as zero
  always_comb begin
    nxt_rdata = '0;
    if (i_reg_addr == CMS_STATUS_OFS) begin
      nxt_rdata[CMS_STS_TX_BUSY] = (tx_state_ff != CMS_TX_IDLE);
      nxt_rdata[CMS_STS_RX_BUSY] = rx_recv_ff;
      nxt_rdata[CMS_STS_PORT_EN] = RX_PORT_EN;
    end else if (i_reg_addr == CMS_COUNT_OFS) begin
      nxt_rdata = {tx_count_ff, rx_count_ff};
    end else begin
      for (int f = 0; f < NUM_FN; f++) begin
        if (i_reg_addr == 8'(CMS_FN_CTL_BASE + f * CMS_FN_CTL_STEP)) begin
          nxt_rdata[CMS_REQ_EN_BIT] = fn_en_ff[f];
          nxt_rdata[CMS_ST_LSB +: CMS_ST_W] = fn_st_ff[f*CMS_ST_W +: CMS_ST_W];
        end
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= i_reg_rd ? nxt_rdata : '0;
    end
  end

  // Two-entry buffer so a busy serializer never drops a decoded message
  assign buf_push = i_link_rx_valid && rx_ready_ff;
  assign buf_pop = (rx_state_ff == CMS_RX_IDLE) && (buf_cnt_ff != '0);
  assign head = buf_mem_ff[rd_ptr_ff];
  assign head_len = head[PAR_W +: CMS_RX_LEN_W];

  always_comb begin
    nxt_buf_cnt = buf_cnt_ff;
    if (buf_push && !buf_pop) begin
      nxt_buf_cnt = buf_cnt_ff + CNT_W'(1);
    end else if (buf_pop && !buf_push) begin
      nxt_buf_cnt = buf_cnt_ff - CNT_W'(1);
    end
  end

  // Ready is registered from the next fill level, so it is honest next cycle
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      buf_cnt_ff <= '0;
      rx_ready_ff <= 1'b0;
    end else begin
      buf_cnt_ff <= nxt_buf_cnt;
      rx_ready_ff <= (nxt_buf_cnt < CNT_W'(BUF_DEPTH));
    end
  end

  // Buffer pointers and storage
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (buf_push) begin
        wr_ptr_ff <= (wr_ptr_ff == PTR_W'(BUF_DEPTH - 1)) ? '0 : wr_ptr_ff + PTR_W'(1);
      end
      if (buf_pop) begin
        rd_ptr_ff <= (rd_ptr_ff == PTR_W'(BUF_DEPTH - 1)) ? '0 : rd_ptr_ff + PTR_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (buf_push) begin
      buf_mem_ff[wr_ptr_ff] <= {i_link_rx_type, i_link_rx_len, i_link_rx_params};
    end
  end

  // Serializer: one parameter byte per cycle; a zero-length message still
  // takes one cycle. Going straight back to idle gives the one-cycle gap.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rx_state_ff <= CMS_RX_IDLE;
      rx_remain_ff <= '0;
      rx_par_ff <= '0;
      rx_recv_ff <= 1'b0;
      rx_data_ff <= '0;
      rx_type_ff <= '0;
    end else begin
      case (rx_state_ff)
        CMS_RX_IDLE: begin
          if (buf_pop && RX_PORT_EN) begin // [RULE8]
            rx_state_ff <= CMS_RX_SEND;
            rx_recv_ff <= 1'b1; // [RULE5]
            rx_type_ff <= head[PAR_W+CMS_RX_LEN_W +: CMS_RX_TYPE_W]; // [RULE9]
            rx_data_ff <= head[CMS_BYTE_W-1:0]; // [RULE6]
            rx_par_ff <= head[PAR_W-1:0] >> CMS_BYTE_W;
            if (head_len == '0) begin
              rx_remain_ff <= CMS_RX_LEN_W'(1);
            end else if (head_len > CMS_RX_LEN_W'(CMS_RX_BYTES)) begin
              rx_remain_ff <= CMS_RX_LEN_W'(CMS_RX_BYTES);
            end else begin
              rx_remain_ff <= head_len;
            end
          end
        end
        CMS_RX_SEND: begin
          if (rx_remain_ff == CMS_RX_LEN_W'(1)) begin
            rx_state_ff <= CMS_RX_IDLE;
            rx_recv_ff <= 1'b0; // [RULE7]
            rx_data_ff <= '0; // [RULE6]
            rx_type_ff <= '0; // [RULE9]
          end else begin
            rx_remain_ff <= rx_remain_ff - CMS_RX_LEN_W'(1); // [RULE5]
            rx_data_ff <= rx_par_ff[CMS_BYTE_W-1:0]; // [RULE6]
            rx_par_ff <= rx_par_ff >> CMS_BYTE_W;
          end
        end
        default: rx_state_ff <= CMS_RX_IDLE;
      endcase
    end
  end

  // Message counters, visible to software, wrap silently
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rx_count_ff <= '0;
      tx_count_ff <= '0;
    end else begin
      if (buf_pop && RX_PORT_EN) begin
        rx_count_ff <= rx_count_ff + CMS_CNT_W'(1);
      end
      if (tx_valid_ff && i_link_tx_ready) begin
        tx_count_ff <= tx_count_ff + CMS_CNT_W'(1);
      end
    end
  end

  // Keep only the fields each message type defines; reserved codes are not sent
  always_comb begin
    tx_reserved = 1'b0;
    case (i_msg_transmit_type) // [RULE11]
      CMS_TX_LTR: tx_mask = CMS_MASK_LTR; // [RULE12]
      CMS_TX_OBFF: tx_mask = CMS_MASK_OBFF; // [RULE13]
      CMS_TX_SSPL: tx_mask = CMS_MASK_SSPL; // [RULE14]
      CMS_TX_PME: tx_mask = CMS_MASK_PME; // [RULE15]
      default: begin
        tx_mask = '0;
        tx_reserved = 1'b1;
      end
    endcase
  end

  // Transmit handshake: the DONE state waits out the cycle in which the user
  // still holds the old request, so it is never taken twice
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tx_state_ff <= CMS_TX_IDLE;
      tx_valid_ff <= 1'b0;
      tx_type_ff <= '0;
      tx_data_ff <= '0;
      tx_done_ff <= 1'b0;
    end else begin
      case (tx_state_ff)
        CMS_TX_IDLE: begin
          tx_done_ff <= 1'b0;
          if (i_msg_transmit && tx_reserved) begin
            tx_state_ff <= CMS_TX_DONE; // [RULE11]
            tx_done_ff <= 1'b1;
          end else if (i_msg_transmit) begin // [RULE10]
            tx_state_ff <= CMS_TX_SEND;
            tx_valid_ff <= 1'b1;
            tx_type_ff <= i_msg_transmit_type;
            tx_data_ff <= i_msg_transmit_data & tx_mask;
          end
        end
        CMS_TX_SEND: begin
          if (i_link_tx_ready) begin
            tx_state_ff <= CMS_TX_DONE;
            tx_valid_ff <= 1'b0;
            tx_done_ff <= 1'b1; // [RULE16]
          end
        end
        CMS_TX_DONE: begin
          tx_state_ff <= CMS_TX_IDLE;
          tx_done_ff <= 1'b0; // [RULE16]
        end
        default: begin
          tx_state_ff <= CMS_TX_IDLE;
          tx_valid_ff <= 1'b0;
          tx_done_ff <= 1'b0;
        end
      endcase
    end
  end

  // Checks on the mirrors, the receive stream and the transmit handshake
  pf_en_mirror_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE1]
    i_reg_wr && i_reg_addr == CMS_FN_CTL_BASE |=>
    o_pf_hint_requester_on[0] == $past(i_reg_wdata[CMS_REQ_EN_BIT]))
    else $error("PF0 requester enable not mirrored");
  pf_st_mirror_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE2]
    i_reg_wr && i_reg_addr == 8'(CMS_FN_CTL_BASE + CMS_FN_CTL_STEP) |=>
    o_pf_steering_tag_select[5:3] == $past(i_reg_wdata[2:0]))
    else $error("PF1 tag select not in bits 5:3");
  vf_en_mirror_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE3]
    i_reg_wr && i_reg_addr == 8'(CMS_FN_CTL_BASE + 4 * CMS_FN_CTL_STEP) |=>
    o_vfn_hint_requester_on[2] == $past(i_reg_wdata[CMS_REQ_EN_BIT]))
    else $error("VF2 requester enable not mirrored");
  vf_st_mirror_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE4]
    i_reg_wr && i_reg_addr == 8'(CMS_FN_CTL_BASE + 7 * CMS_FN_CTL_STEP) |=>
    o_vfn_steering_tag_select[17:15] == $past(i_reg_wdata[2:0]))
    else $error("VF5 tag select not in bits 17:15");
  rx_length_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE5]
    rx_recv_ff && rx_remain_ff > CMS_RX_LEN_W'(1) |=> rx_recv_ff && $stable(rx_type_ff))
    else $error("Received flag dropped before all bytes");
  rx_data_idle_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE6]
    !o_msg_received |-> o_msg_received_data == '0 && o_msg_received_type == '0)
    else $error("Parameter or type bus active while not received");
  rx_gap_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE7]
    rx_recv_ff && rx_remain_ff == CMS_RX_LEN_W'(1) |=> !o_msg_received)
    else $error("No gap between received messages");
  rx_port_off_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE8]
    !RX_PORT_EN |-> !o_msg_received)
    else $error("Message reported with port disabled");
  tx_done_pulse_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE16]
    o_link_tx_valid && i_link_tx_ready |=> o_msg_transmit_done ##1 !o_msg_transmit_done)
    else $error("Done not a single pulse after send");
  tx_reserved_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE11]
    tx_state_ff == CMS_TX_IDLE && i_msg_transmit && i_msg_transmit_type[2] |=>
    o_msg_transmit_done && !o_link_tx_valid)
    else $error("Reserved type not answered at once");
  tx_obff_mask_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE13]
    o_link_tx_valid && o_link_tx_type == CMS_TX_OBFF |-> o_link_tx_data[31:4] == '0)
    else $error("OBFF data above bit 3 not cleared");
endmodule

/* verification/cms_link_model.sv */
// Link-side stand-in: offers decoded messages and takes outgoing ones.
// Assumes the block's user clock; the bench queues messages and sets the stall.
module cms_link_model (
  input wire logic i_clk, // User clock
  input wire logic i_rx_ready, // Block can take a message
  output logic o_rx_valid, // Message offered
  output logic [4:0] o_rx_type, // Offered type
  output logic [3:0] o_rx_len, // Offered byte count
  output logic [63:0] o_rx_params, // Offered bytes, byte 0 low
  input wire logic i_tx_valid, // Block offers a message
  input wire logic [2:0] i_tx_type, // Its type
  input wire logic [31:0] i_tx_data, // Its data
  input wire logic [3:0] i_stall, // Cycles to hold off
  output logic o_tx_ready // Accept
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [72:0] rx_q[$];
  logic [72:0] cur;
  logic [3:0] wait_cnt = 4'h0;
  logic [2:0] last_type = 3'h0;
  logic [31:0] last_data = 32'h0;
  int tx_cnt = 0;
  initial begin
    o_rx_valid = 1'b0;
    {o_rx_type, o_rx_len, o_rx_params} = '0;
  end
  task automatic push(input logic [72:0] m);
    rx_q.push_back(m);
  endtask
  // Next offer once the current one is taken; a released bus shows the inverse
  // so that stale values can never pass for fresh ones
  always @(posedge i_clk) begin
    if ((!o_rx_valid || i_rx_ready) && rx_q.size() > 0) begin
      cur = rx_q.pop_front();
      o_rx_valid <= 1'b1;
      {o_rx_type, o_rx_len, o_rx_params} <= cur;
    end else if (o_rx_valid && i_rx_ready) begin
      o_rx_valid <= 1'b0;
      {o_rx_type, o_rx_len, o_rx_params} <= ~{o_rx_type, o_rx_len, o_rx_params};
    end
  end
  // Outgoing message is held off for i_stall cycles, then taken
  assign o_tx_ready = i_tx_valid && (wait_cnt >= i_stall);
  always @(posedge i_clk) begin
    if (o_tx_ready) begin
      wait_cnt <= 4'h0;
      last_type <= i_tx_type;
      last_data <= i_tx_data;
      tx_cnt <= tx_cnt + 1;
    end else if (i_tx_valid) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

/* verification/cms_cfg_msg_status_tb.sv */
// Self-checking bench of the config message and hint status block.
// Assumes the link model beside it; a second instance is built with the port off.
module cms_cfg_msg_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0, i_reset = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_msg_transmit = 1'b0;
  logic [7:0] i_reg_addr = 8'h0;
  logic [15:0] i_reg_wdata = 16'h0, o_reg_rdata;
  logic [1:0] o_pf_hint_requester_on;
  logic [5:0] o_pf_steering_tag_select, o_vfn_hint_requester_on;
  logic [17:0] o_vfn_steering_tag_select;
  logic i_link_rx_valid, o_link_rx_ready, o_msg_received, o_msg_transmit_done;
  logic o_link_tx_valid, i_link_tx_ready, off_rcv;
  logic [4:0] i_link_rx_type, o_msg_received_type, m_type;
  logic [3:0] i_link_rx_len, tx_stall = 4'h0;
  logic [63:0] i_link_rx_params, m_bytes = 64'h0;
  logic [7:0] o_msg_received_data;
  logic [2:0] i_msg_transmit_type = 3'h0, o_link_tx_type;
  logic [31:0] i_msg_transmit_data = 32'h0, o_link_tx_data;
  logic [31:0] mask [4] = '{32'h9fff_9fff, 32'h0000_000f, 32'h0000_03ff, 32'h0000_03f3};
  logic [72:0] rx_q[$];
  int error_cnt = 0, n_tests = 0, m_len = 0, mon_bad = 0, off_hits = 0;
  cms_cfg_msg_status DUT (.i_clk, .i_reset, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
    .o_reg_rdata, .o_pf_hint_requester_on, .o_pf_steering_tag_select, .o_vfn_hint_requester_on,
    .o_vfn_steering_tag_select, .i_link_rx_valid, .o_link_rx_ready, .i_link_rx_type,
    .i_link_rx_len, .i_link_rx_params, .o_msg_received, .o_msg_received_data,
    .o_msg_received_type, .i_msg_transmit, .i_msg_transmit_type, .i_msg_transmit_data,
    .o_msg_transmit_done, .o_link_tx_valid, .i_link_tx_ready, .o_link_tx_type, .o_link_tx_data);
  // Same stimulus with the receive port disabled at build time
  cms_cfg_msg_status #(.RX_PORT_EN(1'b0)) DUT2 (.i_clk, .i_reset, .i_reg_addr, .i_reg_wdata,
    .i_reg_wr, .i_reg_rd, .o_reg_rdata(), .o_pf_hint_requester_on(), .o_pf_steering_tag_select(),
    .o_vfn_hint_requester_on(), .o_vfn_steering_tag_select(), .i_link_rx_valid,
    .o_link_rx_ready(), .i_link_rx_type, .i_link_rx_len, .i_link_rx_params,
    .o_msg_received(off_rcv), .o_msg_received_data(), .o_msg_received_type(), .i_msg_transmit,
    .i_msg_transmit_type, .i_msg_transmit_data, .o_msg_transmit_done(), .o_link_tx_valid(),
    .i_link_tx_ready(1'b1), .o_link_tx_type(), .o_link_tx_data());
  cms_link_model u_link (.i_clk, .i_rx_ready(o_link_rx_ready), .o_rx_valid(i_link_rx_valid),
    .o_rx_type(i_link_rx_type), .o_rx_len(i_link_rx_len), .o_rx_params(i_link_rx_params),
    .i_tx_valid(o_link_tx_valid), .i_tx_type(o_link_tx_type), .i_tx_data(o_link_tx_data),
    .i_stall(tx_stall), .o_tx_ready(i_link_tx_ready));
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  // Wide enough for a whole gathered message: type, length and eight bytes
  task automatic chk(input string what, input logic [72:0] exp, input logic [72:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Register master: one-cycle strobes, read data looked at only in the next cycle
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    @(negedge i_clk);
    chk("reg read", exp, o_reg_rdata);
    @(posedge i_clk);
  endtask
  // Transmit request held with type and data until done, then dropped
  task automatic tx(input logic [2:0] t, input logic [3:0] stall);
    int n, c0;
    c0 = u_link.tx_cnt;
    tx_stall <= stall;
    i_msg_transmit <= 1'b1;
    i_msg_transmit_type <= t;
    i_msg_transmit_data <= 32'hffff_ffff;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_msg_transmit_done !== 1'b1 && n < 30);
    chk("tx done", 1, o_msg_transmit_done);
    @(posedge i_clk);
    i_msg_transmit <= 1'b0;
    @(negedge i_clk);
    chk("tx done width", 0, o_msg_transmit_done);
    chk("tx sent", (t < 3'h4) ? c0 + 1 : c0, u_link.tx_cnt);
    if (t < 3'h4) begin
      chk("tx type", t, u_link.last_type);
      chk("tx data", mask[t], u_link.last_data);
    end
    @(posedge i_clk);
  endtask
  // Gathers each reported message; type must hold and data must be zero between
  always @(posedge i_clk) begin
    if (!i_reset) begin
      if (off_rcv === 1'b1) off_hits++;
      if (o_msg_received === 1'b1) begin
        if (m_len == 0) m_type = o_msg_received_type;
        else if (o_msg_received_type !== m_type) mon_bad++;
        if (m_len < 8) m_bytes[8*m_len+:8] = o_msg_received_data;
        m_len++;
      end else begin
        if (o_msg_received_data !== 8'h0) mon_bad++;
        if (m_len > 0) rx_q.push_back({m_type, m_len[3:0], m_bytes});
        m_len = 0;
        m_bytes = 64'h0;
      end
    end
  end
  initial begin
    #50000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    logic [17:0] vst;
    logic [5:0] pst, ven;
    logic [1:0] pen;
    logic en;
    logic [2:0] tag;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    // Looked at mid-cycle so the values are settled, not racing the edge
    @(negedge i_clk);
    chk("reset mirrors", 0, {o_pf_hint_requester_on, o_vfn_hint_requester_on});
    chk("rx ready in reset", 0, o_link_rx_ready);
    @(posedge i_clk);
    reg_rd(8'h00, 16'h0000);
    reg_rd(8'h20, 16'h0004);
    chk("rx ready after reset", 1, o_link_rx_ready);
    $display("test reset done");
    // Every function word, reserved bits set, then mirrors and read-back
    for (int f = 0; f < 8; f++) begin
      en = ~f[0];
      tag = f[2:0] + 3'h5;
      reg_wr(8'(4 * f), {7'h7f, en, 5'h1f, tag});
      if (f < 2) {pen[f], pst[3*f+:3]} = {en, tag};
      else {ven[f-2], vst[3*(f-2)+:3]} = {en, tag};
    end
    chk("pf enable", pen, o_pf_hint_requester_on);
    chk("pf tag select", pst, o_pf_steering_tag_select);
    chk("vf enable", ven, o_vfn_hint_requester_on);
    chk("vf tag select", vst, o_vfn_steering_tag_select);
    reg_wr(8'h40, 16'hffff);
    reg_rd(8'h40, 16'h0000);
    for (int f = 0; f < 8; f++) reg_rd(8'(4 * f), {7'h0, ~f[0], 5'h0, f[2:0] + 3'h5});
    $display("test mirrors done");
    // Three offers back to back fill the buffer; a zero-length one still shows a cycle
    u_link.push({5'h10, 4'h2, 64'h0000_0000_0000_bbaa});
    u_link.push({5'h1f, 4'h0, 64'h0});
    u_link.push({5'h01, 4'h8, 64'h8877_6655_4433_2211});
    repeat (40) @(posedge i_clk);
    chk("rx count", 3, rx_q.size());
    chk("rx first", {5'h10, 4'h2, 64'hbbaa}, rx_q[0]);
    chk("rx second", {5'h1f, 4'h1, 64'h0}, rx_q[1]);
    chk("rx third", {5'h01, 4'h8, 64'h8877_6655_4433_2211}, rx_q[2]);
    chk("rx side faults", 0, mon_bad);
    chk("rx port off", 0, off_hits);
    $display("test receive done");
    // Each code with all data bits set, a stalled link, then a reserved code
    for (int t = 0; t < 4; t++) tx(t[2:0], t[3:0]);
    tx(3'h5, 4'h0);
    reg_rd(8'h24, 16'h0403);
    $display("test transmit done");
    wrap_up();
  end
endmodule
